/* File: rtl/flash_erase_dev.sv */
// Purpose: Flash device end: erase family and power-state commands
// Assumes: SPI mode 0, bits sampled on sclk rise, MSB first
// Notes: Frame capture runs on sclk; decisions run on clk after cs_n rises
`timescale 1ns/100ps
`default_nettype none
module flash_erase_dev #(
   parameter int ERASE_CYC = flash_erase_pkg::ERASE_CYCLES,
   parameter int CHIP_CYC = flash_erase_pkg::CHIP_ERASE_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   spi_link_if.dev link,
   // Protection setting
   input wire logic [4:0] block_protect_bits,
   input wire logic protect_complement,
   // Status
   output logic write_enable_latch,
   output logic write_in_progress,
   output logic ready_busy_on,
   output logic powered_down,
   // Erase engine request
   output logic erase_start,
   output logic [1:0] erase_kind,
   output logic [23:0] erase_base
);
   typedef enum logic [2:0] {
      st_powerup, st_standby, st_erase, st_pd_enter, st_powerdown, st_pd_exit
   } dev_state_t;

   // Link domain frame capture
   logic first_q;
   logic [5:0] cnt_q;
   logic [31:0] shf_q;

   always_ff @(posedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         first_q <= 1'b1;
      end else begin
         first_q <= 1'b0;
      end
   end

   always_ff @(posedge link.sclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 6'h00;
         shf_q <= 32'h0000_0000;
      end else begin
         cnt_q <= first_q ? 6'h01 :
            (cnt_q == flash_erase_pkg::LEN_SAT) ? cnt_q : cnt_q + 6'h01;
         shf_q <= {shf_q[30:0], link.si};
      end
   end

   // Chip select crossing; frame registers are still while cs_n is high
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= link.cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
      end
   end

   wire cs_rise = cs_s2_q & ~cs_s3_q;
   wire len8 = (cnt_q == flash_erase_pkg::LEN_OPCODE);
   wire len32 = (cnt_q == flash_erase_pkg::LEN_ADDR_CMD);
   wire [7:0] op8 = shf_q[7:0];
   wire [7:0] op32 = shf_q[31:24];
   wire [23:0] addr = shf_q[23:0];

   wire is_set_latch = len8 && op8 == flash_erase_pkg::OP_SET_LATCH;
   wire is_sec = len32 && op32 == flash_erase_pkg::OP_SECTOR_ERASE;
   wire is_b32 = len32 && op32 == flash_erase_pkg::OP_BLOCK32_ERASE;
   wire is_b64 = len32 && op32 == flash_erase_pkg::OP_BLOCK64_ERASE;
   wire is_chip = len8 && (op8 == flash_erase_pkg::OP_CHIP_ERASE_A ||
      op8 == flash_erase_pkg::OP_CHIP_ERASE_B);
   wire is_rb_on = len8 && op8 == flash_erase_pkg::OP_RB_ON;
   wire is_rb_off = len8 && op8 == flash_erase_pkg::OP_RB_OFF;
   wire is_pd_cmd = len8 && op8 == flash_erase_pkg::OP_POWERDOWN;
   wire is_rel = len8 && op8 == flash_erase_pkg::OP_RELEASE;

   // guarded blocks counted from the top
   wire [2:0] bp_lo = block_protect_bits[2:0];
   wire [3:0] span = (bp_lo == 3'h0) ? 4'h0 :
      (bp_lo >= 3'h4) ? flash_erase_pkg::BLK_COUNT :
      4'(4'h1 << (bp_lo - 3'h1));
   wire [3:0] blk_end = {1'b0, addr[flash_erase_pkg::BLK_LSB +: 3]} + span;
   wire guarded = (blk_end >= flash_erase_pkg::BLK_COUNT) ^
      protect_complement;
   wire chip_ok = (bp_lo == 3'h0 && !protect_complement) ||
      (bp_lo == 3'h7 && protect_complement);

   wire [23:0] base = is_sec ? (addr & flash_erase_pkg::MASK_SECTOR) :
      is_b32 ? (addr & flash_erase_pkg::MASK_BLOCK32) :
      (addr & flash_erase_pkg::MASK_BLOCK64);
   wire [1:0] kind = is_sec ? flash_erase_pkg::KIND_SECTOR :
      is_b32 ? flash_erase_pkg::KIND_BLOCK32 :
      flash_erase_pkg::KIND_BLOCK64;
   wire go_area = (is_sec | is_b32 | is_b64) & write_enable_latch & ~guarded;
   wire go_chip = is_chip & write_enable_latch & chip_ok;

   dev_state_t st_q, st_d;
   logic [31:0] tmr_q, tmr_d;
   logic wel_d, rb_d, start_d;
   logic [1:0] kind_d;
   logic [23:0] base_d;
   wire tmr_done = (tmr_q == 32'h0000_0001);

   always_comb begin
      st_d = st_q;
      tmr_d = (tmr_q == 32'h0000_0000) ? tmr_q : tmr_q - 32'h0000_0001;
      wel_d = write_enable_latch;
      rb_d = ready_busy_on;
      start_d = 1'b0;
      kind_d = erase_kind;
      base_d = erase_base;
      case (st_q)
         st_powerup: begin
            if (tmr_done) begin
               st_d = st_standby;
            end
         end
         st_standby: begin
            if (cs_rise) begin
               if (is_set_latch) begin
                  wel_d = 1'b1;
               end
               if (is_rb_on) begin
                  rb_d = 1'b1;
               end
               if (is_rb_off) begin
                  rb_d = 1'b0;
               end
               // timed cycle starts at frame end
               if (go_area || go_chip) begin
                  st_d = st_erase;
                  start_d = 1'b1;
                  kind_d = go_chip ? flash_erase_pkg::KIND_CHIP : kind;
                  base_d = go_chip ? 24'h000000 : base;
                  tmr_d = go_chip ? 32'(CHIP_CYC) : 32'(ERASE_CYC);
                  wel_d = 1'b0;
               end
               if (is_pd_cmd) begin
                  st_d = st_pd_enter;
                  tmr_d = 32'(flash_erase_pkg::POWERDOWN_ENTRY_CYCLES);
               end
            end
         end
         st_erase: begin
            if (tmr_done) begin
               st_d = st_standby;
            end
         end
         st_pd_enter: begin
            if (tmr_done) begin
               st_d = st_powerdown;
            end
         end
         st_powerdown: begin
            if (cs_rise && is_rel) begin
               st_d = st_pd_exit;
               tmr_d = 32'(flash_erase_pkg::RELEASE_CYCLES);
            end
         end
         st_pd_exit: begin
            if (tmr_done) begin
               st_d = st_standby;
            end
         end
         default: begin
            st_d = st_standby;
         end
      endcase
   end

   logic so_q, so_oe_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= st_powerup;
         tmr_q <= 32'(flash_erase_pkg::POWERUP_CYCLES);
         write_enable_latch <= 1'b0;
         ready_busy_on <= 1'b0;
         erase_start <= 1'b0;
         erase_kind <= flash_erase_pkg::KIND_SECTOR;
         erase_base <= 24'h000000;
         write_in_progress <= 1'b0;
         powered_down <= 1'b0;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         write_enable_latch <= wel_d;
         ready_busy_on <= rb_d;
         erase_start <= start_d;
         erase_kind <= kind_d;
         erase_base <= base_d;
         write_in_progress <= (st_d == st_erase);
         powered_down <= (st_d == st_powerdown);
         // low while busy, high in standby
         so_q <= (st_d == st_standby);
         so_oe_q <= rb_d;
      end
   end

   assign link.so_o = so_q;
   assign link.so_oe = so_oe_q;
endmodule
`default_nettype wire

/* File: rtl/flash_erase_pkg.sv */
// Purpose: Shared constants for the serial flash erase and power-state link
// Assumes: Device state logic and host run on clk at 10 MHz
// Notes: Times are in microseconds; cycle counts derive from the clock rate
package flash_erase_pkg;
   localparam int CLK_MHZ = 10;
   // Opcodes
   localparam logic [7:0] OP_SET_LATCH = 8'h06;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
   localparam logic [7:0] OP_RB_ON = 8'h70;
   localparam logic [7:0] OP_RB_OFF = 8'h80;
   localparam logic [7:0] OP_POWERDOWN = 8'hB9;
   localparam logic [7:0] OP_RELEASE = 8'hAB;
   // Frame lengths in bits
   localparam logic [5:0] LEN_OPCODE = 6'h08;
   localparam logic [5:0] LEN_ADDR_CMD = 6'h20;
   localparam logic [5:0] LEN_SAT = 6'h21;
   // Region masks that clear the offset inside sector and blocks
   localparam logic [23:0] MASK_SECTOR = 24'hFFF000;
   localparam logic [23:0] MASK_BLOCK32 = 24'hFF8000;
   localparam logic [23:0] MASK_BLOCK64 = 24'hFF0000;
   // Protection map: eight 64KB blocks, top blocks guarded first
   localparam int BLK_LSB = 16;
   localparam logic [3:0] BLK_COUNT = 4'h8;
   // Erase kinds
   localparam logic [1:0] KIND_SECTOR = 2'h0;
   localparam logic [1:0] KIND_BLOCK32 = 2'h1;
   localparam logic [1:0] KIND_BLOCK64 = 2'h2;
   localparam logic [1:0] KIND_CHIP = 2'h3;
   // Times in microseconds
   localparam int ERASE_CYCLE_TIME_US = 50000;
   localparam int CHIP_ERASE_TIME_US = 2000000;
   localparam int POWERDOWN_ENTRY_DELAY_US = 3;
   localparam int RELEASE_RECOVERY_TIME_US = 3;
   localparam int POWERUP_TIME_US = 10;
   // Cycle counts
   localparam int ERASE_CYCLES = ERASE_CYCLE_TIME_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_TIME_US * CLK_MHZ;
   localparam int POWERDOWN_ENTRY_CYCLES = POWERDOWN_ENTRY_DELAY_US * CLK_MHZ;
   localparam int RELEASE_CYCLES = RELEASE_RECOVERY_TIME_US * CLK_MHZ;
   localparam int POWERUP_CYCLES = POWERUP_TIME_US * CLK_MHZ;
   // Host keeps chip select high this long between frames
   localparam logic [15:0] HOST_GAP_CYCLES = 16'h0008;
   localparam logic [15:0] HOST_RELEASE_CYCLES = 16'(RELEASE_CYCLES + 8);
endpackage

/* File: rtl/spi_link_if.sv */
// Purpose: Serial link between host controller and flash device
// Assumes: Data-out idles high through a pull-up when not driven
// Notes: No clocking block; the bench joins both ends here
`timescale 1ns/100ps
`default_nettype none
interface spi_link_if;
   logic cs_n;
   logic sclk;
   logic si;
   logic so_o;
   logic so_oe;
   wire so;
   assign so = so_oe ? so_o : 1'b1;
   modport dev (
      input cs_n,
      input sclk,
      input si,
      output so_o,
      output so_oe
   );
   modport hst (
      output cs_n,
      output sclk,
      output si,
      input so
   );
endinterface
`default_nettype wire

/* File: rtl/flash_erase_host.sv */
// Purpose: Host end: sends erase and power-state frames to the flash
// Assumes: sclk is clk divided by two, mode 0, MSB first
// Notes: Erase requests get a write-enable frame sent ahead automatically
`timescale 1ns/100ps
`default_nettype none
module flash_erase_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   spi_link_if.hst link,
   // Command request
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_op,
   input wire logic [23:0] cmd_addr,
   output logic cmd_ready,
   output logic cmd_done,
   // Ready/busy level seen on data-out
   output logic ready_level
);
   typedef enum logic [1:0] {h_idle, h_shift, h_gap} host_state_t;

   wire has_addr = (cmd_op == flash_erase_pkg::OP_SECTOR_ERASE) ||
      (cmd_op == flash_erase_pkg::OP_BLOCK32_ERASE) ||
      (cmd_op == flash_erase_pkg::OP_BLOCK64_ERASE);
   wire is_erase = has_addr || (cmd_op == flash_erase_pkg::OP_CHIP_ERASE_A) ||
      (cmd_op == flash_erase_pkg::OP_CHIP_ERASE_B);

   host_state_t st_q;
   logic [31:0] fr_q, pend_fr_q;
   logic [5:0] bits_q, pend_bits_q;
   logic pend_q, rel_q, cs_n_q, sclk_q, si_q;
   logic [15:0] gap_q;
   logic so_s1_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         so_s1_q <= 1'b1;
         ready_level <= 1'b1;
      end else begin
         so_s1_q <= link.so;
         ready_level <= so_s1_q;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= h_idle;
         fr_q <= 32'h0000_0000;
         pend_fr_q <= 32'h0000_0000;
         bits_q <= 6'h00;
         pend_bits_q <= 6'h00;
         pend_q <= 1'b0;
         rel_q <= 1'b0;
         gap_q <= 16'h0000;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b0;
         si_q <= 1'b0;
         cmd_ready <= 1'b1;
         cmd_done <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         case (st_q)
            h_idle: begin
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  cs_n_q <= 1'b0;
                  st_q <= h_shift;
                  rel_q <= (cmd_op == flash_erase_pkg::OP_RELEASE);
                  if (is_erase) begin
                     pend_q <= 1'b1;
                     fr_q <= {flash_erase_pkg::OP_SET_LATCH, 24'h000000};
                     si_q <= flash_erase_pkg::OP_SET_LATCH[7];
                     bits_q <= flash_erase_pkg::LEN_OPCODE;
                  end else begin
                     fr_q <= {cmd_op, 24'h000000};
                     si_q <= cmd_op[7];
                     bits_q <= flash_erase_pkg::LEN_OPCODE;
                  end
                  pend_fr_q <= {cmd_op, cmd_addr};
                  pend_bits_q <= has_addr ? flash_erase_pkg::LEN_ADDR_CMD :
                     flash_erase_pkg::LEN_OPCODE;
               end
            end
            h_shift: begin
               if (!sclk_q) begin
                  sclk_q <= 1'b1;
               end else begin
                  sclk_q <= 1'b0;
                  fr_q <= {fr_q[30:0], 1'b0};
                  si_q <= fr_q[30];
                  bits_q <= bits_q - 6'h01;
                  // deselect right after the last bit
                  if (bits_q == 6'h01) begin
                     cs_n_q <= 1'b1;
                     st_q <= h_gap;
                     gap_q <= rel_q ? flash_erase_pkg::HOST_RELEASE_CYCLES :
                        flash_erase_pkg::HOST_GAP_CYCLES;
                  end
               end
            end
            h_gap: begin
               gap_q <= gap_q - 16'h0001;
               if (gap_q == 16'h0001) begin
                  if (pend_q) begin
                     pend_q <= 1'b0;
                     fr_q <= pend_fr_q;
                     si_q <= pend_fr_q[31];
                     bits_q <= pend_bits_q;
                     cs_n_q <= 1'b0;
                     st_q <= h_shift;
                  end else begin
                     st_q <= h_idle;
                     cmd_ready <= 1'b1;
                     cmd_done <= 1'b1;
                  end
               end
            end
            default: begin
               st_q <= h_idle;
            end
         endcase
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.si = si_q;
endmodule
`default_nettype wire

/* File: tb/flash_link_props.sv */
// Purpose: Checks on the link between host and flash device ends
// Assumes: cs_n, sclk and si come from host flops on clk
// Notes: so is seen after the pull-up
`timescale 1ns/100ps
`default_nettype none
module flash_link_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic si,
   input wire logic so_oe,
   input wire logic so
);
   logic [5:0] bits_q;
   logic sclk_q;
   logic cs_q;
   wire logic bit_rise = !cs_n && sclk && !sclk_q;
   wire logic idle_gap = cs_n && cs_q;

   // Counts sclk rises within one frame
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bits_q <= 6'h00;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
      end else begin
         sclk_q <= sclk;
         cs_q <= cs_n;
         if (bit_rise) begin
            bits_q <= bits_q + 6'h01;
         end else if (idle_gap) begin
            bits_q <= 6'h00;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_frame_whole: assert property (
      $rose(cs_n) |-> (bits_q == flash_erase_pkg::LEN_OPCODE ||
                       bits_q == flash_erase_pkg::LEN_ADDR_CMD))
      else $error("frame not 8 or 32 bits");
   a_cs_gap: assert property (
      $rose(cs_n) |-> cs_n [*5])
      else $error("chip select gap too short");
   a_sclk_idle: assert property (
      cs_n |-> !sclk)
      else $error("sclk moves while deselected");
   a_first_rise: assert property (
      $fell(cs_n) |-> !sclk ##1 sclk)
      else $error("first sclk rise misplaced");
   a_si_steady: assert property (
      sclk |-> $stable(si))
      else $error("si changed while sclk high");
   a_sclk_pulse: assert property (
      sclk |=> !sclk)
      else $error("sclk high too long");
   a_oe_on_cmd: assert property (
      $changed(so_oe) |-> cs_n && $past(cs_n, 3))
      else $error("so enable changed outside command end");
   a_busy_after_end: assert property (
      so_oe && $fell(so) |-> cs_n && $past(cs_n, 3))
      else $error("busy without a finished frame");
   a_busy_hold: assert property (
      so_oe && $fell(so) |-> (!so) [*8])
      else $error("busy level too short");

   c_long_frame: cover property (
      $rose(cs_n) && bits_q == flash_erase_pkg::LEN_ADDR_CMD);
   c_busy: cover property (so_oe && $fell(so));
   c_ready: cover property (so_oe && $rose(so));
endmodule
`default_nettype wire

/* File: tb/spi_flash_erase_powerdown_cmds_bench.sv */
// Purpose: Self-checking bench joining host and flash device ends
// Assumes: Erase counts shortened to 50 and 80 clk cycles
// Notes: A second link is driven by the bench to send bad frames
`timescale 1ns/100ps
`default_nettype none
module spi_flash_erase_powerdown_cmds_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   logic [7:0] cmd_op = 8'h00;
   logic [23:0] cmd_addr = 24'h000000;
   logic [4:0] bp = 5'h00;
   logic prot_inv = 1'b0;
   logic cmd_ready, cmd_done, rdy, latch, busy, rb_on, pd, est, busy_b, est_b;
   logic [1:0] kind, kind_seen;
   logic [23:0] base, base_seen;
   logic [23:0] starts = 24'h000000;
   logic [23:0] starts_b = 24'h000000;
   logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
   logic [1:0] kinds [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
   logic [23:0] bases [5] = '{24'h12B000, 24'h128000, 24'h120000,
                              24'h000000, 24'h000000};
   int bad_count = 0;
   int n_compared = 0;
   spi_link_if link_a ();
   spi_link_if link_b ();

   always #50 clk = ~clk;

   flash_erase_dev #(.ERASE_CYC(50), .CHIP_CYC(80)) u_flash_erase_dev (
      .clk(clk), .rst(rst), .link(link_a), .block_protect_bits(bp),
      .protect_complement(prot_inv), .write_enable_latch(latch),
      .write_in_progress(busy), .ready_busy_on(rb_on), .powered_down(pd),
      .erase_start(est), .erase_kind(kind), .erase_base(base));
   flash_erase_dev #(.ERASE_CYC(50), .CHIP_CYC(80)) u_flash_erase_dev_b (
      .clk(clk), .rst(rst), .link(link_b), .block_protect_bits(bp),
      .protect_complement(prot_inv), .write_enable_latch(),
      .write_in_progress(busy_b), .ready_busy_on(), .powered_down(),
      .erase_start(est_b), .erase_kind(), .erase_base());
   flash_erase_host u_flash_erase_host (
      .clk(clk), .rst(rst), .link(link_a), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_ready(cmd_ready),
      .cmd_done(cmd_done), .ready_level(rdy));
   flash_link_props chk (
      .clk(clk), .rst(rst), .cs_n(link_a.cs_n), .sclk(link_a.sclk),
      .si(link_a.si), .so_oe(link_a.so_oe), .so(link_a.so));

   always @(posedge clk) begin
      if (est === 1'b1) begin
         starts <= starts + 24'h000001;
         kind_seen <= kind;
         base_seen <= base;
      end
      if (est_b === 1'b1) begin
         starts_b <= starts_b + 24'h000001;
      end
   end

   task automatic check(input string what, input logic [23:0] exp,
                        input logic [23:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic run_cmd(input logic [7:0] op, input logic [23:0] addr);
      int n;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_addr <= addr;
      @(posedge clk);
      cmd_valid <= 1'b0;
      n = 0;
      while (cmd_done !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      check("cmd_done", 24'h000001, {23'h000000, cmd_done});
      check("cmd_ready", 24'h000001, {23'h000000, cmd_ready});
      repeat (4) @(negedge clk);
   endtask

   // Bench-made frame on the second link, 160 ns sclk, MSB first
   task automatic frame_b(input logic [39:0] v, input int n);
      link_b.cs_n <= 1'b0;
      #37;
      for (int i = n - 1; i >= 0; i--) begin
         link_b.si <= v[i];
         #80 link_b.sclk <= 1'b1;
         #80 link_b.sclk <= 1'b0;
      end
      #40 link_b.cs_n <= 1'b1;
      link_b.si <= ~link_b.si;
      #2000;
   endtask

   task automatic set_protect(input logic [4:0] b, input logic c);
      @(posedge clk);
      bp <= b;
      prot_inv <= c;
   endtask

   initial begin
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.si = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (120) @(negedge clk);
      check("busy after powerup", 24'h0, busy);
      check("powered_down after powerup", 24'h0, pd);
      run_cmd(8'h70, 24'h000000);
      check("ready_busy_on", 24'h1, rb_on);
      check("ready_level idle", 24'h1, rdy);
      for (int i = 0; i < 5; i++) begin
         run_cmd(ops[i], 24'h12B456);
         check("erase starts", 24'(i + 1), starts);
         check("erase_kind", kinds[i], kind_seen);
         check("erase_base", bases[i], base_seen);
         check("busy in erase", 24'h1, busy);
         check("latch cleared", 24'h0, latch);
         check("ready_level busy", 24'h0, rdy);
         repeat (100) @(negedge clk);
         check("busy done", 24'h0, busy);
         check("ready_level ready", 24'h1, rdy);
      end
      set_protect(5'h01, 1'b0);
      run_cmd(8'h20, 24'h07F000);
      check("guarded sector", 24'h5, starts);
      run_cmd(8'hD8, 24'h06FFFF);
      check("unguarded block", 24'h6, starts);
      repeat (100) @(negedge clk);
      run_cmd(8'h60, 24'h000000);
      check("chip erase guarded", 24'h6, starts);
      set_protect(5'h07, 1'b1);
      run_cmd(8'hC7, 24'h000000);
      check("chip erase complement", 24'h7, starts);
      repeat (100) @(negedge clk);
      set_protect(5'h00, 1'b0);
      run_cmd(8'h20, 24'h001000);
      run_cmd(8'hB9, 24'h000000);
      repeat (40) @(negedge clk);
      check("powerdown during erase", 24'h0, pd);
      check("erase survived", 24'h8, starts);
      check("busy after erase", 24'h0, busy);
      run_cmd(8'hB9, 24'h000000);
      check("powerdown delay", 24'h0, pd);
      repeat (40) @(negedge clk);
      check("powered_down", 24'h1, pd);
      check("ready_level powerdown", 24'h0, rdy);
      run_cmd(8'h20, 24'h000000);
      check("erase in powerdown", 24'h8, starts);
      run_cmd(8'hAB, 24'h000000);
      repeat (40) @(negedge clk);
      check("released", 24'h0, pd);
      check("ready_level released", 24'h1, rdy);
      run_cmd(8'h80, 24'h000000);
      check("ready_busy_on off", 24'h0, rb_on);
      run_cmd(8'h52, 24'h000000);
      check("erase after release", 24'h9, starts);
      check("ready_level undriven", 24'h1, rdy);
      repeat (100) @(negedge clk);
      frame_b(40'h06, 8);
      frame_b(40'h20002345, 31);
      frame_b(40'h120002345, 33);
      frame_b(40'h0C7, 9);
      check("bad frames", 24'h0, starts_b);
      frame_b(40'h20002345, 32);
      check("link b start", 24'h1, starts_b);
      check("link b busy", 24'h1, busy_b);
      repeat (100) @(negedge clk);
      frame_b(40'h20002345, 32);
      check("erase without latch", 24'h1, starts_b);
      finish_test();
   end

   initial begin
      #2000000;
      bad_count++;
      $display("[ERR] watchdog expected end seen hang");
      finish_test();
   end
endmodule
`default_nettype wire
